/* File: tcm_consts.vh */
// Purpose: constants for the 16-bit timer compare/output block
// Assumes: APB slave, 32-bit data, one word per register
// Notes: offsets and bit positions below are all named here
//
// Overview of operation
// [R01] count write blocks next tick's compare matches
// [R02] written count equal TOP loses TOP match
// [R03] output bit kept across waveform changes
// [R04] action select unbuffered, used at next match
// [R05] reset clears the output bits
// [R06] nonzero action select overrides port value
// [R07] action select never touches capture
// [R08] action zero leaves output unchanged
// [R09] force strobe applies action in non-PWM
// [R10] only waveform select chooses counting
// [R11] mode 0 counts up, wraps at max
// [R12] normal mode overflow when count becomes zero
// [R13] overflow flag sticky, cleared by software
// [R14] clear-on-match mode clears at A or capture
// [R15] unbuffered TOP below count runs to wrap
// [R16] TOP reach sets A or capture flag
// [R17] action 1 toggles output on match
// [R18] tick prescale 1, 8, 64, 256, 1024
// [R19] clear-on-match overflow only at max wrap
// [R20] modes 5,6,7,14,15 are fast PWM
// [R21] non-inverting PWM clears at match, sets bottom
// [R22] software sets output before pin direction
// [R23] match flag set one tick after equality
// [R24] forced match sets no flag, no clear
// [R25] compare buffered only in PWM modes
// [R26] fast PWM TOP fixed or capture or A
// [R27] counting only on tick, writes any time
`ifndef TCM_CONSTS_VH
`define TCM_CONSTS_VH

`define TCM_ADDR_W 8
`define TCM_OFS_CTRL 8'h00
`define TCM_OFS_COUNT 8'h04
`define TCM_OFS_CMPA 8'h08
`define TCM_OFS_CMPB 8'h0c
`define TCM_OFS_CAPT 8'h10
`define TCM_OFS_FLAGS 8'h14
`define TCM_OFS_PORT 8'h18

// control register fields
`define TCM_CTRL_WGM_LSB 0
`define TCM_CTRL_WGM_MSB 3
`define TCM_CTRL_CSA_LSB 4
`define TCM_CTRL_CSA_MSB 5
`define TCM_CTRL_CSB_LSB 6
`define TCM_CTRL_CSB_MSB 7
`define TCM_CTRL_PRE_LSB 8
`define TCM_CTRL_PRE_MSB 10
`define TCM_CTRL_FOCA 11
`define TCM_CTRL_FOCB 12

// flag register bits (write one to clear)
`define TCM_FLAG_OVF 0
`define TCM_FLAG_MA 1
`define TCM_FLAG_MB 2
`define TCM_FLAG_CAP 3

// port register bits
`define TCM_PORT_VAL_A 0
`define TCM_PORT_VAL_B 1
`define TCM_PORT_DIR_A 2
`define TCM_PORT_DIR_B 3
`define TCM_PORT_OUT_A 4
`define TCM_PORT_OUT_B 5

// waveform select codes
`define TCM_WGM_NORMAL 4'h0
`define TCM_WGM_CTC_A 4'h4
`define TCM_WGM_FP8 4'h5
`define TCM_WGM_FP9 4'h6
`define TCM_WGM_FP10 4'h7
`define TCM_WGM_CTC_CAP 4'hc
`define TCM_WGM_FP_CAP 4'he
`define TCM_WGM_FP_A 4'hf

// output action codes
`define TCM_COM_NONE 2'h0
`define TCM_COM_TOGGLE 2'h1
`define TCM_COM_CLEAR 2'h2
`define TCM_COM_SET 2'h3

// prescale select codes
`define TCM_PRE_STOP 3'h0
`define TCM_PRE_DIV1 3'h1
`define TCM_PRE_DIV8 3'h2
`define TCM_PRE_DIV64 3'h3
`define TCM_PRE_DIV256 3'h4
`define TCM_PRE_DIV1024 3'h5
`define TCM_PRE_TAP8 10'h007
`define TCM_PRE_TAP64 10'h03f
`define TCM_PRE_TAP256 10'h0ff
`define TCM_PRE_TAP1024 10'h3ff

`define TCM_MAX 16'hffff
`define TCM_BOTTOM 16'h0000
`define TCM_TOP8 16'h00ff
`define TCM_TOP9 16'h01ff
`define TCM_TOP10 16'h03ff

`endif

/* File: tcm_timer16.v */
// Purpose: 16-bit timer with normal, clear-on-match and fast PWM modes
// Assumes: APB slave on pclk; always ready, no wait states
// Notes: two compare channels, A and B, each with an output bit
`timescale 1ns/1ps
`default_nettype none
`include "tcm_consts.vh"

module tcm_timer16 (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`TCM_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire capture_event,
    input wire [15:0] capture_count_in,
    output reg compare_a_output,
    output reg compare_b_output,
    output reg pin_a_value,
    output reg pin_b_value,
    output wire output_a_pin_direction_bit,
    output wire output_b_pin_direction_bit
);

    // ------------------------
    // register state
    // ------------------------
    reg [3:0] waveform_select_q;
    reg [1:0] output_a_action_select_q;
    reg [1:0] output_b_action_select_q;
    reg [2:0] prescale_q;
    reg [15:0] timer_count_q;
    reg [15:0] compare_a_value_q;
    reg [15:0] compare_b_value_q;
    reg [15:0] compare_a_buf_q;
    reg [15:0] compare_b_buf_q;
    reg [15:0] capture_value_q;
    reg overflow_flag_q;
    reg match_a_flag_q;
    reg match_b_flag_q;
    reg capture_flag_q;
    reg [3:0] port_q;
    reg block_q;
    reg [9:0] prediv_q;
    reg [15:0] cap_sync1_q;
    reg [15:0] cap_sync2_q;
    reg capev_sync1_q;
    reg capev_sync2_q;
    reg capev_prev_q;
    reg match_a_pend_q;
    reg match_b_pend_q;

    wire wr_en = psel & penable & pwrite;
    wire wr_ctrl = wr_en && (paddr == `TCM_OFS_CTRL);
    wire wr_count = wr_en && (paddr == `TCM_OFS_COUNT);
    wire wr_cmpa = wr_en && (paddr == `TCM_OFS_CMPA);
    wire wr_cmpb = wr_en && (paddr == `TCM_OFS_CMPB);
    wire wr_capt = wr_en && (paddr == `TCM_OFS_CAPT);
    wire wr_flags = wr_en && (paddr == `TCM_OFS_FLAGS);
    wire wr_port = wr_en && (paddr == `TCM_OFS_PORT);

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign output_a_pin_direction_bit = port_q[`TCM_PORT_DIR_A];
    assign output_b_pin_direction_bit = port_q[`TCM_PORT_DIR_B];

    // ------------------------
    // prescaler
    // ------------------------
    reg tick;
    always @* begin
        case (prescale_q)
            `TCM_PRE_DIV1: tick = 1'b1; // see [R18]
            `TCM_PRE_DIV8: tick = ((prediv_q & `TCM_PRE_TAP8) == `TCM_PRE_TAP8);
            `TCM_PRE_DIV64: tick = ((prediv_q & `TCM_PRE_TAP64) == `TCM_PRE_TAP64);
            `TCM_PRE_DIV256: tick = ((prediv_q & `TCM_PRE_TAP256) == `TCM_PRE_TAP256);
            `TCM_PRE_DIV1024: tick = (prediv_q == `TCM_PRE_TAP1024);
            default: tick = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prediv_q <= 10'h000;
        end else begin
            prediv_q <= prediv_q + 10'h001;
        end
    end

    // ------------------------
    // mode decode
    // ------------------------
    // only the waveform select shapes counting; actions never do
    reg is_pwm;
    reg top_is_cap;
    reg top_is_a;
    reg [15:0] top;
    always @* begin
        is_pwm = 1'b0;
        top_is_cap = 1'b0;
        top_is_a = 1'b0;
        top = `TCM_MAX;
        case (waveform_select_q) // see [R10]
            `TCM_WGM_CTC_A: begin
                top_is_a = 1'b1; // see [R14]
                top = compare_a_value_q;
            end
            `TCM_WGM_CTC_CAP: begin
                top_is_cap = 1'b1;
                top = capture_value_q;
            end
            `TCM_WGM_FP8: begin
                is_pwm = 1'b1; // see [R20]
                top = `TCM_TOP8; // see [R26]
            end
            `TCM_WGM_FP9: begin
                is_pwm = 1'b1;
                top = `TCM_TOP9;
            end
            `TCM_WGM_FP10: begin
                is_pwm = 1'b1;
                top = `TCM_TOP10;
            end
            `TCM_WGM_FP_CAP: begin
                is_pwm = 1'b1;
                top_is_cap = 1'b1;
                top = capture_value_q;
            end
            `TCM_WGM_FP_A: begin
                is_pwm = 1'b1;
                top_is_a = 1'b1;
                top = compare_a_value_q;
            end
            default: begin
                top = `TCM_MAX; // see [R11]
            end
        endcase
    end

    wire has_top = is_pwm | top_is_a | top_is_cap;
    // blocked matches include the TOP match, so the count runs to max
    wire eq_top = has_top && (timer_count_q == top) && !block_q; // see [R02]
    wire eq_a = (timer_count_q == compare_a_value_q) && !block_q; // see [R01]
    wire eq_b = (timer_count_q == compare_b_value_q) && !block_q;
    wire at_max = (timer_count_q == `TCM_MAX);
    wire [15:0] count_inc = timer_count_q + 16'h0001;

    // ------------------------
    // counter and blocking
    // ------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count_q <= `TCM_BOTTOM;
            block_q <= 1'b0;
        end else if (wr_count) begin
            timer_count_q <= pwdata[15:0];
            block_q <= 1'b1; // see [R01]
        end else if (tick) begin // see [R27]
            block_q <= 1'b0;
            if (eq_top) begin
                timer_count_q <= `TCM_BOTTOM; // see [R14] [R20]
            end else begin
                timer_count_q <= count_inc; // see [R15]
            end
        end
    end

    // ------------------------
    // compare registers
    // ------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_a_value_q <= 16'h0000;
            compare_b_value_q <= 16'h0000;
            compare_a_buf_q <= 16'h0000;
            compare_b_buf_q <= 16'h0000;
            capture_value_q <= 16'h0000;
        end else begin
            if (wr_cmpa) begin
                compare_a_buf_q <= pwdata[15:0];
            end
            if (wr_cmpb) begin
                compare_b_buf_q <= pwdata[15:0];
            end
            if (!is_pwm) begin
                if (wr_cmpa) begin
                    compare_a_value_q <= pwdata[15:0]; // see [R25]
                end
                if (wr_cmpb) begin
                    compare_b_value_q <= pwdata[15:0];
                end
            end else if (tick && eq_top) begin
                compare_a_value_q <= compare_a_buf_q;
                compare_b_value_q <= compare_b_buf_q;
            end
            if (wr_capt) begin
                capture_value_q <= pwdata[15:0];
            end else if (capev_sync2_q && !capev_prev_q && !top_is_cap) begin
                capture_value_q <= cap_sync2_q; // see [R07]
            end
        end
    end

    // ------------------------
    // capture input crossing
    // ------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_sync1_q <= 16'h0000;
            cap_sync2_q <= 16'h0000;
            capev_sync1_q <= 1'b0;
            capev_sync2_q <= 1'b0;
            capev_prev_q <= 1'b0;
        end else begin
            cap_sync1_q <= capture_count_in;
            cap_sync2_q <= cap_sync1_q;
            capev_sync1_q <= capture_event;
            capev_sync2_q <= capev_sync1_q;
            capev_prev_q <= capev_sync2_q;
        end
    end

    // ------------------------
    // flags
    // ------------------------
    wire ovf_ev = tick && (has_top ? (is_pwm ? eq_top : at_max) : at_max); // see [R12] [R19]
    wire cap_ev = (capev_sync2_q && !capev_prev_q && !top_is_cap) ||
        (tick && top_is_cap && eq_top); // see [R16]
    wire ma_set = tick && match_a_pend_q; // see [R23]
    wire mb_set = tick && match_b_pend_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_q <= 1'b0;
            match_a_flag_q <= 1'b0;
            match_b_flag_q <= 1'b0;
            capture_flag_q <= 1'b0;
            match_a_pend_q <= 1'b0;
            match_b_pend_q <= 1'b0;
        end else begin
            if (tick) begin
                match_a_pend_q <= eq_a;
                match_b_pend_q <= eq_b;
            end
            // set wins over a same-cycle clear
            overflow_flag_q <= ovf_ev |
                (overflow_flag_q & ~(wr_flags & pwdata[`TCM_FLAG_OVF])); // see [R13]
            match_a_flag_q <= ma_set | (match_a_flag_q & ~(wr_flags & pwdata[`TCM_FLAG_MA]));
            match_b_flag_q <= mb_set | (match_b_flag_q & ~(wr_flags & pwdata[`TCM_FLAG_MB]));
            capture_flag_q <= cap_ev |
                (capture_flag_q & ~(wr_flags & pwdata[`TCM_FLAG_CAP]));
        end
    end

    // ------------------------
    // output bits
    // ------------------------
    function out_next;
        input cur;
        input [1:0] act;
        input pwm;
        input match;
        input bottom;
        input force_it;
        begin
            out_next = cur; // see [R03] [R08]
            if (pwm) begin
                if (act == `TCM_COM_CLEAR) begin
                    if (match) out_next = 1'b0; // see [R21]
                    else if (bottom) out_next = 1'b1;
                end else if (act == `TCM_COM_SET) begin
                    if (match) out_next = 1'b1;
                    else if (bottom) out_next = 1'b0;
                end else if (act == `TCM_COM_TOGGLE) begin
                    if (match) out_next = ~cur;
                end
            end else if (match || force_it) begin // see [R09] [R24]
                case (act) // see [R04]
                    `TCM_COM_TOGGLE: out_next = ~cur; // see [R17]
                    `TCM_COM_CLEAR: out_next = 1'b0;
                    `TCM_COM_SET: out_next = 1'b1;
                    default: out_next = cur;
                endcase
            end
        end
    endfunction

    // toggle in PWM only meaningful on channel A with top from A
    wire pwm_tog_a = (waveform_select_q == `TCM_WGM_FP_A);
    wire bottom_ev = tick && eq_top;
    wire foc_a = wr_ctrl && pwdata[`TCM_CTRL_FOCA] && !is_pwm;
    wire foc_b = wr_ctrl && pwdata[`TCM_CTRL_FOCB] && !is_pwm;
    wire [1:0] act_b_eff = (is_pwm && output_b_action_select_q == `TCM_COM_TOGGLE) ?
        `TCM_COM_NONE : output_b_action_select_q;
    wire [1:0] act_a_eff = (is_pwm && !pwm_tog_a &&
        output_a_action_select_q == `TCM_COM_TOGGLE) ? `TCM_COM_NONE : output_a_action_select_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_a_output <= 1'b0; // see [R05]
            compare_b_output <= 1'b0;
        end else begin
            compare_a_output <= out_next(compare_a_output, act_a_eff, is_pwm,
                tick && eq_a, bottom_ev, foc_a);
            compare_b_output <= out_next(compare_b_output, act_b_eff, is_pwm,
                tick && eq_b, bottom_ev, foc_b);
        end
    end

    // ------------------------
    // pin value mux
    // ------------------------
    // direction still gates the pin outside; pad logic not here
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_value <= 1'b0;
            pin_b_value <= 1'b0;
        end else begin
            pin_a_value <= (output_a_action_select_q != `TCM_COM_NONE) ?
                compare_a_output : port_q[`TCM_PORT_VAL_A]; // see [R06]
            pin_b_value <= (output_b_action_select_q != `TCM_COM_NONE) ?
                compare_b_output : port_q[`TCM_PORT_VAL_B];
        end
    end

    // ------------------------
    // control and port registers
    // ------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            waveform_select_q <= `TCM_WGM_NORMAL;
            output_a_action_select_q <= `TCM_COM_NONE;
            output_b_action_select_q <= `TCM_COM_NONE;
            prescale_q <= `TCM_PRE_STOP;
            port_q <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                waveform_select_q <= pwdata[`TCM_CTRL_WGM_MSB:`TCM_CTRL_WGM_LSB];
                output_a_action_select_q <= pwdata[`TCM_CTRL_CSA_MSB:`TCM_CTRL_CSA_LSB];
                output_b_action_select_q <= pwdata[`TCM_CTRL_CSB_MSB:`TCM_CTRL_CSB_LSB];
                prescale_q <= pwdata[`TCM_CTRL_PRE_MSB:`TCM_CTRL_PRE_LSB];
            end
            if (wr_port) begin
                port_q <= pwdata[3:0]; // see [R22]
            end
        end
    end

    // ------------------------
    // read data
    // ------------------------
    always @* begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (paddr)
                `TCM_OFS_CTRL: prdata = {21'h000000, prescale_q, output_b_action_select_q,
                    output_a_action_select_q, waveform_select_q};
                `TCM_OFS_COUNT: prdata = {16'h0000, timer_count_q};
                `TCM_OFS_CMPA: prdata = {16'h0000, is_pwm ? compare_a_buf_q : compare_a_value_q};
                `TCM_OFS_CMPB: prdata = {16'h0000, is_pwm ? compare_b_buf_q : compare_b_value_q};
                `TCM_OFS_CAPT: prdata = {16'h0000, capture_value_q};
                `TCM_OFS_FLAGS: prdata = {28'h0000000, capture_flag_q, match_b_flag_q,
                    match_a_flag_q, overflow_flag_q};
                `TCM_OFS_PORT: prdata = {26'h0000000, compare_b_output, compare_a_output,
                    port_q};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

endmodule
`default_nettype wire

/* File: tcm_timer16_monitor.sv */
// Purpose: port-level checks for the 16-bit timer compare block
// Assumes: bus always ready, a write commits at psel&penable&pwrite
// Notes: CTRL and PORT are shadowed from bus writes to know the modes
`timescale 1ns/1ps
`default_nettype none
`include "tcm_consts.vh"

module tcm_timer16_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`TCM_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire compare_a_output,
    input wire compare_b_output,
    input wire pin_a_value,
    input wire output_a_pin_direction_bit
);
    // ----------------------------------------
    // shadow state
    // ----------------------------------------
    logic [10:0] ctrl_q;
    logic [1:0] port_q;
    wire wr = psel && penable && pwrite;
    wire ctrl_wr = wr && paddr == `TCM_OFS_CTRL;
    // force only judged with timer stopped, so no real match can interfere
    wire frc_a = ctrl_wr && pwdata[`TCM_CTRL_FOCA]
        && ctrl_q[3:0] == `TCM_WGM_NORMAL && ctrl_q[10:8] == `TCM_PRE_STOP
        && pwdata[3:0] == `TCM_WGM_NORMAL && pwdata[10:8] == `TCM_PRE_STOP;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 11'h000;
            port_q <= 2'h0;
        end else if (ctrl_wr) begin
            ctrl_q <= pwdata[10:0];
        end else if (wr && paddr == `TCM_OFS_PORT) begin
            port_q <= {pwdata[`TCM_PORT_DIR_A], pwdata[`TCM_PORT_VAL_A]};
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_out_low: assert property ($rose(presetn) |-> !compare_a_output && !compare_b_output)
        else $error("output bit high after reset");
    a_force_set: assert property (frc_a && ctrl_q[5:4] == `TCM_COM_SET |=> compare_a_output)
        else $error("forced set missed");
    a_force_clear: assert property (frc_a && ctrl_q[5:4] == `TCM_COM_CLEAR |=> !compare_a_output)
        else $error("forced clear missed");
    a_force_toggle: assert property (frc_a && ctrl_q[5:4] == `TCM_COM_TOGGLE
        |=> compare_a_output != $past(compare_a_output))
        else $error("forced toggle missed");
    a_idle_keeps: assert property (ctrl_q[5:4] == `TCM_COM_NONE && !ctrl_wr
        |=> $stable(compare_a_output))
        else $error("output changed with no action");
    a_mode_keep: assert property (ctrl_wr && pwdata[5:4] == 2'h0 && ctrl_q[5:4] == 2'h0
        && !pwdata[`TCM_CTRL_FOCA] && pwdata[3:0] != ctrl_q[3:0] |=> $stable(compare_a_output))
        else $error("output changed on mode change");
    a_pin_override: assert property ($past(presetn)
        |-> pin_a_value == $past(ctrl_q[5:4] != 2'h0 ? compare_a_output : port_q[0]))
        else $error("pin value source wrong");
    a_dir_follow: assert property (wr && paddr == `TCM_OFS_PORT
        |=> output_a_pin_direction_bit == $past(pwdata[`TCM_PORT_DIR_A]))
        else $error("direction bit not updated");
    a_bus_no_error: assert property (psel |-> pready && !pslverr)
        else $error("bus wait or error seen");
    a_unmapped_read: assert property (psel && !pwrite && paddr > `TCM_OFS_PORT |-> prdata == 32'h0)
        else $error("unmapped read not zero");

    c_force: cover property (frc_a);
    c_pin_over: cover property (ctrl_q[5:4] != 2'h0 && port_q[1] && pin_a_value);
    c_ctc_toggle: cover property (ctrl_q[3:0] == `TCM_WGM_CTC_A && $changed(compare_a_output));
endmodule

bind tcm_timer16 tcm_timer16_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compare_a_output(compare_a_output),
    .compare_b_output(compare_b_output), .pin_a_value(pin_a_value),
    .output_a_pin_direction_bit(output_a_pin_direction_bit));
`default_nettype wire

/* File: tcm_pin_model.sv */
// Purpose: port pin with direction control beside the timer
// Assumes: direction bit high means the pin is driven
// Notes: pad has a pull-up, so a released pad never holds old data
`timescale 1ns/1ps
`default_nettype none

module tcm_pin_model (
    input wire logic pin_value,
    input wire logic pin_dir,
    output wire logic pad
);
    assign pad = pin_dir ? pin_value : 1'b1;
endmodule
`default_nettype wire

/* File: timer16_compare_output_modes_test.sv */
// Purpose: self-checking bench for the 16-bit timer compare block
// Assumes: zero-wait bus; capture input unused and held low
// Notes: count reads carry several ticks of slack, the count moves meanwhile
`timescale 1ns/1ps
`default_nettype none
`include "tcm_consts.vh"

module timer16_compare_output_modes_test;
    logic pclk, presetn, psel, penable, pwrite, v;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire pready, pslverr, out_a, out_b, pin_a, pin_b, dir_a, dir_b, pad_a, pad_b;
    int failures, comparisons, tg;
    int divs [5] = '{1, 8, 64, 256, 1024};
    logic [7:0] acts = {`TCM_COM_NONE, `TCM_COM_TOGGLE, `TCM_COM_CLEAR, `TCM_COM_SET};
    logic [3:0] outs = 4'b1101;

    tcm_timer16 DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_event(1'b0), .capture_count_in(16'h0000),
        .compare_a_output(out_a), .compare_b_output(out_b), .pin_a_value(pin_a),
        .pin_b_value(pin_b), .output_a_pin_direction_bit(dir_a),
        .output_b_pin_direction_bit(dir_b));
    tcm_pin_model u_pad_a (.pin_value(pin_a), .pin_dir(dir_a), .pad(pad_a));
    tcm_pin_model u_pad_b (.pin_value(pin_b), .pin_dir(dir_b), .pad(pad_b));

    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) failures++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask

    task automatic wctl(input logic [3:0] m, input logic [1:0] a, input logic [2:0] p);
        apb(1'b1, `TCM_OFS_CTRL, {21'h0, p, 2'h0, a, m});
    endtask

    task automatic halt(input logic [3:0] m);
        wctl(m, `TCM_COM_NONE, `TCM_PRE_STOP);
    endtask

    task automatic end_of_test;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // longest test is about 14.5k cycles
    initial begin
        repeat (40000) @(posedge pclk);
        failures++;
        end_of_test();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`TCM_OFS_CTRL, 32'h0);
        rdc(`TCM_OFS_PORT, 32'h0);
        rdc(8'h1c, 32'h0);
        wr(`TCM_OFS_COUNT, 32'h1234);
        // force applies the stored action, so store it first
        for (int i = 0; i < 4; i++) begin
            wctl(`TCM_WGM_NORMAL, acts[2*i+:2], `TCM_PRE_STOP);
            wr(`TCM_OFS_CTRL, {20'h0, 1'b1, 5'h0, acts[2*i+:2], `TCM_WGM_NORMAL});
            check({31'h0, out_a}, {31'h0, outs[i]});
        end
        rdc(`TCM_OFS_COUNT, 32'h1234);
        rdc(`TCM_OFS_FLAGS, 32'h0);
        // output bit first, then pin enabled, port value 0
        wr(`TCM_OFS_PORT, 32'h4);
        @(negedge pclk);
        check({27'h0, dir_b, pad_b, pin_b, pin_a, pad_a}, 32'h8);
        wctl(`TCM_WGM_NORMAL, `TCM_COM_TOGGLE, `TCM_PRE_STOP);
        @(negedge pclk);
        check({27'h0, dir_b, pad_b, pin_b, pin_a, pad_a}, 32'hb);
        rdc(`TCM_OFS_PORT, 32'h14);
        wr(`TCM_OFS_CMPA, 32'h40);
        wr(`TCM_OFS_COUNT, 32'h40);
        wr(`TCM_OFS_FLAGS, 32'hf);
        wctl(`TCM_WGM_NORMAL, `TCM_COM_TOGGLE, `TCM_PRE_DIV1);
        wctl(`TCM_WGM_NORMAL, `TCM_COM_TOGGLE, `TCM_PRE_STOP);
        rdc(`TCM_OFS_FLAGS, 32'h0);
        check({31'h0, out_a}, 32'h1);
        wr(`TCM_OFS_COUNT, 32'h3c);
        // toggle here would drop the bit, set must win
        wctl(`TCM_WGM_NORMAL, `TCM_COM_SET, `TCM_PRE_DIV1);
        repeat (8) @(posedge pclk);
        halt(`TCM_WGM_NORMAL);
        rdc(`TCM_OFS_FLAGS, 32'h2);
        check({31'h0, out_a}, 32'h1);
        wr(`TCM_OFS_FLAGS, 32'hf);
        wr(`TCM_OFS_COUNT, 32'hfffa);
        wctl(`TCM_WGM_NORMAL, `TCM_COM_NONE, `TCM_PRE_DIV1);
        repeat (8) @(posedge pclk);
        halt(`TCM_WGM_NORMAL);
        apb(1'b0, `TCM_OFS_COUNT, 32'h0);
        check({31'h0, rd < 32'h20}, 32'h1);
        // compare B still 0, so passing zero sets its flag too
        rdc(`TCM_OFS_FLAGS, 32'h5);
        wctl(`TCM_WGM_NORMAL, `TCM_COM_NONE, `TCM_PRE_DIV1);
        halt(`TCM_WGM_NORMAL);
        rdc(`TCM_OFS_FLAGS, 32'h5);
        wr(`TCM_OFS_FLAGS, 32'h1);
        rdc(`TCM_OFS_FLAGS, 32'h4);
        wr(`TCM_OFS_COUNT, 32'h0);
        wr(`TCM_OFS_CMPA, 32'h3);
        wr(`TCM_OFS_FLAGS, 32'hf);
        wctl(`TCM_WGM_CTC_A, `TCM_COM_TOGGLE, `TCM_PRE_DIV1);
        tg = 0;
        for (int i = 0; i < 20; i++) begin
            v = out_a;
            apb(1'b0, `TCM_OFS_COUNT, 32'h0);
            check({31'h0, rd <= 32'h3}, 32'h1);
            tg += (out_a != v);
        end
        halt(`TCM_WGM_CTC_A);
        check({31'h0, tg > 0}, 32'h1);
        apb(1'b0, `TCM_OFS_FLAGS, 32'h0);
        check(rd & 32'h3, 32'h2);
        wr(`TCM_OFS_COUNT, 32'h10);
        wctl(`TCM_WGM_CTC_A, `TCM_COM_NONE, `TCM_PRE_DIV1);
        repeat (16) @(posedge pclk);
        halt(`TCM_WGM_CTC_A);
        apb(1'b0, `TCM_OFS_COUNT, 32'h0);
        check({31'h0, rd > 32'h10}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            wr(`TCM_OFS_COUNT, 32'h0);
            wctl(`TCM_WGM_NORMAL, `TCM_COM_NONE, 3'(i + 1));
            repeat (10 * divs[i]) @(posedge pclk);
            halt(`TCM_WGM_NORMAL);
            apb(1'b0, `TCM_OFS_COUNT, 32'h0);
            check({31'h0, rd >= 32'h9 && rd <= 32'he}, 32'h1);
        end
        wr(`TCM_OFS_COUNT, 32'h0);
        wr(`TCM_OFS_CMPA, 32'h80);
        wctl(`TCM_WGM_FP8, `TCM_COM_CLEAR, `TCM_PRE_DIV1);
        tg = 0;
        for (int i = 0; i < 200; i++) begin
            apb(1'b0, `TCM_OFS_COUNT, 32'h0);
            check({31'h0, rd <= 32'hff}, 32'h1);
            tg |= out_a ? 1 : 2;
        end
        check(tg, 32'h3);
        halt(`TCM_WGM_FP8);
        v = out_a;
        halt(`TCM_WGM_NORMAL);
        check({31'h0, out_a}, {31'h0, v});
        end_of_test();
    end
endmodule
`default_nettype wire
